// ==== design/tmrh_core.v ====
// Purpose: Three 8-bit up-counting compare timers with output control, APB slave
// Assumes: Single clock clk_sys (25 MHz), synchronous active-high reset
// Notes:   Instance 2 has no pin; its output gates the event counter input
//
// Behaviour
// - Counter compared with period compare always; match raises irq, toggles output.
// - Reset clears period and duty compare of all instances to zero.
// - Duty compare matches only in PWM and carrier modes, unused in interval.
// - PWM mode duty match toggles output, raises no interrupt.
// - Carrier mode duty match raises interrupt and clears counter same cycle.
// - Duty writes while counting buffered, applied when counter hits old value.
// - Duty match coinciding with duty write leaves active value unchanged.
// - Third instance has no pin; match drives irq or event input gating.
// - Carrier mode only on second instance, combinable with partner timer.
// - Square-wave output only on first and second instances.
// - Each instance: 8-bit counter, two compare registers, output controller.
// - Enable low stops and zeroes counter; high advances on count clock.
//
// The APB interface to the registers and the register addresses were decided locally.
`include "tmrh_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// One timer instance
// ----------------------------------------------------------------------------
module tcoc_unit #(
  parameter HAS_CARRIER = 0
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       tick,
  input  wire       en,
  input  wire [1:0] mode,
  input  wire       tolev,
  input  wire       period_wr,
  input  wire       duty_wr,
  input  wire [7:0] wdata,
  output reg  [7:0] period_reg,
  output reg  [7:0] duty_act_reg,
  output reg  [7:0] count_reg,
  output reg        match_reg,
  output reg        tout_reg
);
  reg  [7:0] duty_buf_reg;
  reg        pending_reg;
  wire       is_carrier;
  wire       is_pwm;
  wire       hit_period;
  wire       hit_duty;

  assign is_carrier = (HAS_CARRIER != 0) && (mode == `TMRH_MODE_CARRIER);
  assign is_pwm     = (mode == `TMRH_MODE_PWM);
  assign hit_period = en && tick && (count_reg == period_reg);
  assign hit_duty   = en && tick && (count_reg == duty_act_reg);

  // Period compare: plain store, software keeps it steady while counting
  always @(posedge clk_sys) begin
    if (rst) begin
      period_reg <= `TMRH_RST_COMPARE;
    end else if (period_wr) begin
      period_reg <= wdata;
    end
  end

  // Duty compare with holding buffer
  always @(posedge clk_sys) begin
    if (rst) begin
      duty_act_reg <= `TMRH_RST_COMPARE;
      duty_buf_reg <= `TMRH_RST_COMPARE;
      pending_reg  <= 1'b0;
    end else if (duty_wr) begin
      duty_buf_reg <= wdata;
      if (!en) begin
        duty_act_reg <= wdata;
        pending_reg  <= 1'b0;
      end else begin
        // Write while counting: active copy kept, value waits for next hit
        pending_reg  <= 1'b1;
      end
    end else if (hit_duty && pending_reg) begin
      duty_act_reg <= duty_buf_reg;
      pending_reg  <= 1'b0;
    end
  end

  // Counter, match pulse and output flip-flop
  always @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= 8'h00;
      match_reg <= 1'b0;
      tout_reg  <= 1'b0;
    end else if (!en) begin
      count_reg <= 8'h00;
      match_reg <= 1'b0;
      tout_reg  <= tolev;
    end else begin
      match_reg <= hit_period || (is_carrier && hit_duty);
      if (hit_period ^ (is_pwm && hit_duty)) begin
        tout_reg <= ~tout_reg;
      end
      if (tick) begin
        if (is_carrier && hit_duty) begin
          count_reg <= 8'h00;
        end else if (hit_period) begin
          count_reg <= 8'h00;
        end else begin
          count_reg <= count_reg + 8'h01;
        end
      end
    end
  end
endmodule // tcoc_unit

// ----------------------------------------------------------------------------
// Top: APB slave, prescaler, interrupts, three instances
// ----------------------------------------------------------------------------
module tcoc_core #(
  parameter NUM_INST = 3
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        carrier_partner_timer,
  output reg  [1:0]  timer_out_pin,
  output wire        event_count_enable,
  output reg         carrier_out,
  output wire [2:0]  match_irq,
  output wire        irq
);
  reg  [7:0]  mode_control_reg [0:2];
  reg  [2:0]  irq_status_reg;
  reg  [2:0]  irq_mask_reg;
  reg         err_reg;
  reg  [`TMRH_PRESC_W-1:0] presc_reg;
  reg  [31:0] rdata_next;
  reg         err_next;
  wire [7:0]  period_w [0:2];
  wire [7:0]  duty_w   [0:2];
  wire [7:0]  count_w  [0:2];
  wire [2:0]  tout_w;
  wire [2:0]  tick_w;
  wire [1:0]  inst_sel;
  wire [3:0]  reg_ofs;
  wire        inst_hit;
  wire        wr_go;
  integer     k;

  assign pready   = 1'b1;
  assign pslverr  = psel && penable && err_reg;
  assign inst_sel = paddr[5:4];
  assign reg_ofs  = paddr[3:0];
  assign inst_hit = (paddr[7:6] == 2'b00) && (inst_sel <= `TMRH_LAST_INST);
  assign wr_go    = psel && penable && pwrite && !err_reg;
  assign irq      = |(irq_status_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // Prescaler; free running so every instance sees the same phase
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      presc_reg <= {`TMRH_PRESC_W{1'b0}};
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  function [3:0] tmrh_shift;
    input [2:0] sel;
    begin
      case (sel)
        3'd1:    tmrh_shift = `TMRH_SHIFT_SEL1;
        3'd2:    tmrh_shift = `TMRH_SHIFT_SEL2;
        3'd3:    tmrh_shift = `TMRH_SHIFT_SEL3;
        3'd4:    tmrh_shift = `TMRH_SHIFT_SEL4;
        3'd5:    tmrh_shift = `TMRH_SHIFT_SEL5;
        default: tmrh_shift = `TMRH_SHIFT_SEL0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_INST; g = g + 1) begin : g_inst
      wire [3:0]  sh;
      wire [11:0] lowmask;
      wire        duty_wr;
      wire        period_wr;
      assign sh        = tmrh_shift(mode_control_reg[g][`TMRH_CKS_HI:`TMRH_CKS_LO]);
      assign lowmask   = ~({12{1'b1}} << sh);
      assign tick_w[g] = ((presc_reg & lowmask) == lowmask);
      assign period_wr = wr_go && inst_hit && (inst_sel == g) && (reg_ofs == `TMRH_OFS_PERIOD);
      assign duty_wr   = wr_go && inst_hit && (inst_sel == g) && (reg_ofs == `TMRH_OFS_DUTY);
      tcoc_unit #(
        .HAS_CARRIER (g == 1)
      ) u_unit (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .tick         (tick_w[g]),
        .en           (mode_control_reg[g][`TMRH_BIT_ENABLE]),
        .mode         (mode_control_reg[g][`TMRH_MODE_HI:`TMRH_MODE_LO]),
        .tolev        (mode_control_reg[g][`TMRH_BIT_TOLEV]),
        .period_wr    (period_wr),
        .duty_wr      (duty_wr),
        .wdata        (pwdata[7:0]),
        .period_reg   (period_w[g]),
        .duty_act_reg (duty_w[g]),
        .count_reg    (count_w[g]),
        .match_reg    (match_irq[g]),
        .tout_reg     (tout_w[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Output controller; only instances 0 and 1 own a pin
  // --------------------------------------------------------------------------
  assign event_count_enable = tout_w[2];

  always @(posedge clk_sys) begin
    if (rst) begin
      timer_out_pin <= 2'b00;
      carrier_out   <= 1'b0;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        timer_out_pin[k] <= mode_control_reg[k][`TMRH_BIT_TOEN] && tout_w[k];
      end
      // Carrier gated by the partner timer level
      carrier_out <= (mode_control_reg[1][`TMRH_MODE_HI:`TMRH_MODE_LO] == `TMRH_MODE_CARRIER)
                     && tout_w[1] && carrier_partner_timer;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers and interrupts
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      for (k = 0; k < 3; k = k + 1) begin
        mode_control_reg[k] <= `TMRH_RST_MODE;
      end
      irq_status_reg <= `TMRH_RST_IRQ;
      irq_mask_reg   <= `TMRH_RST_IRQ;
    end else begin
      if (wr_go && inst_hit && (reg_ofs == `TMRH_OFS_MODE)) begin
        mode_control_reg[inst_sel] <= pwdata[7:0];
      end
      if (wr_go && (paddr == `TMRH_ADDR_MASK)) begin
        irq_mask_reg <= pwdata[2:0];
      end
      // Set wins over a simultaneous write-one clear
      if (wr_go && (paddr == `TMRH_ADDR_STATUS)) begin
        irq_status_reg <= (irq_status_reg & ~pwdata[2:0]) | match_irq;
      end else begin
        irq_status_reg <= irq_status_reg | match_irq;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path: decoded in setup, presented from flops in access
  // --------------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (inst_hit) begin
      case (reg_ofs)
        `TMRH_OFS_MODE:   rdata_next[7:0] = mode_control_reg[inst_sel];
        `TMRH_OFS_PERIOD: rdata_next[7:0] = period_w[inst_sel];
        `TMRH_OFS_DUTY:   rdata_next[7:0] = duty_w[inst_sel];
        `TMRH_OFS_COUNT:  rdata_next[7:0] = count_w[inst_sel];
        default:          err_next = 1'b1;
      endcase
    end else if (paddr == `TMRH_ADDR_STATUS) begin
      rdata_next[2:0] = irq_status_reg;
    end else if (paddr == `TMRH_ADDR_MASK) begin
      rdata_next[2:0] = irq_mask_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= rdata_next;
      err_reg <= err_next;
    end
  end
endmodule // tcoc_core

`default_nettype wire

// ==== design/tmrh_defines.vh ====
// Purpose: Constants for the three-instance 8-bit compare/output timer core
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes:   Per-instance block stride is 16 bytes
`ifndef TMRH_DEFINES_VH
`define TMRH_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TMRH_ADDR_W        8
`define TMRH_INST_STRIDE   8'h10
`define TMRH_OFS_MODE      4'h0
`define TMRH_OFS_PERIOD    4'h4
`define TMRH_OFS_DUTY      4'h8
`define TMRH_OFS_COUNT     4'hC
`define TMRH_ADDR_STATUS   8'h30
`define TMRH_ADDR_MASK     8'h34
`define TMRH_LAST_INST     2'h2

// ----------------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------------
`define TMRH_BIT_ENABLE    7
`define TMRH_CKS_HI        6
`define TMRH_CKS_LO        4
`define TMRH_MODE_HI       3
`define TMRH_MODE_LO       2
`define TMRH_BIT_TOLEV     1
`define TMRH_BIT_TOEN      0

`define TMRH_MODE_INTERVAL 2'h0
`define TMRH_MODE_CARRIER  2'h1
`define TMRH_MODE_PWM      2'h2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TMRH_RST_MODE      8'h00
`define TMRH_RST_COMPARE   8'h00
`define TMRH_RST_IRQ       3'h0

// ----------------------------------------------------------------------------
// Prescaler: count clock = clk_sys / 2**shift
// ----------------------------------------------------------------------------
`define TMRH_PRESC_W       12
`define TMRH_SHIFT_SEL0    4'd0
`define TMRH_SHIFT_SEL1    4'd1
`define TMRH_SHIFT_SEL2    4'd2
`define TMRH_SHIFT_SEL3    4'd4
`define TMRH_SHIFT_SEL4    4'd6
`define TMRH_SHIFT_SEL5    4'd12

`endif

// ==== test/tcoc_chk.sv ====
// Purpose: Port-level checks for the compare/output timer core
// Assumes: One clock, sync active-high reset
// Notes:   Shadows mode and mask writes to qualify checks
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module tcoc_chk #(
  parameter NUM_INST = 3
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [1:0]  timer_out_pin,
  input wire logic        event_count_enable,
  input wire logic        carrier_out,
  input wire logic [2:0]  match_irq,
  input wire logic        irq
);
  logic [7:0] m0_reg;
  logic [7:0] m1_reg;
  logic [7:0] m2_reg;
  logic [2:0] mk_reg;
  wire        wr_hit = psel && penable && pwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Mode shadows, so checks know whether a match may toggle
  always @(posedge clk_sys) begin
    if (rst) begin
      m0_reg <= 8'h00;
      m1_reg <= 8'h00;
      m2_reg <= 8'h00;
      mk_reg <= 3'h0;
    end else if (wr_hit) begin
      if (paddr == 8'h00) m0_reg <= pwdata[7:0];
      if (paddr == 8'h10) m1_reg <= pwdata[7:0];
      if (paddr == 8'h20) m2_reg <= pwdata[7:0];
      if (paddr == 8'h34) mk_reg <= pwdata[2:0];
    end
  end
  property p_rst;
    @(posedge clk_sys) disable iff (1'b0)
    rst |=> match_irq == 3'h0 && timer_out_pin == 2'h0 && !irq;
  endproperty
  property p_tog;
    match_irq[0] && $stable(m0_reg) && m0_reg[7] && m0_reg[0] && m0_reg[3:2] == 2'h0
    |=> timer_out_pin[0] != $past(timer_out_pin[0]);
  endproperty
  property p_stop;
    !m0_reg[7] && $past(!m0_reg[7]) |-> !match_irq[0];
  endproperty
  property p_toen;
    !m1_reg[0] && $past(!m1_reg[0]) |-> !timer_out_pin[1];
  endproperty
  property p_map;
    psel && penable && paddr == 8'h40 |-> pslverr;
  endproperty
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  property p_mask;
    mk_reg == 3'h0 |-> !irq;
  endproperty
  property p_car;
    m1_reg[3:2] != 2'h1 && $past(m1_reg[3:2] != 2'h1) |-> !carrier_out;
  endproperty
  property p_evt;
    m2_reg[7] && m2_reg[3:2] != 2'h2 && $stable(m2_reg) && $past(m2_reg[7], 2)
    && $changed(event_count_enable)
    |-> match_irq[2] || $past(match_irq[2]);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_tog: assert property (p_tog) else $error("period match did not toggle");
  a_stop: assert property (p_stop) else $error("match while stopped");
  a_toen: assert property (p_toen) else $error("pin driven while disabled");
  a_map: assert property (p_map) else $error("unmapped access not refused");
  a_err: assert property (p_err) else $error("error outside access phase");
  a_mask: assert property (p_mask) else $error("irq high while all masked");
  a_car: assert property (p_car) else $error("carrier outside carrier mode");
  a_evt: assert property (p_evt) else $error("gate moved without match");
  c_m0: cover property (match_irq[0]);
  c_m1: cover property (match_irq[1] && m1_reg[3:2] == 2'h1);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule // tcoc_chk
bind tcoc_core tcoc_chk #(.NUM_INST(NUM_INST)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .timer_out_pin(timer_out_pin),
  .event_count_enable(event_count_enable), .carrier_out(carrier_out),
  .match_irq(match_irq), .irq(irq));
`default_nettype wire

// ==== test/tb_timer_compare_output_core.sv ====
// Purpose: Self-checking bench for the compare/output timer core
// Assumes: 25 MHz clock, zero-wait APB slave
// Notes:   Directed scenarios, one task each
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module tb_timer_compare_output_core;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd_q;
  logic [1:0]  pins;
  logic [2:0]  mirq;
  logic        pready;
  logic        pslverr;
  logic        cpt = 1'b1;
  logic        car;
  logic        er_q;
  logic        ece;
  logic        irq;
  wire  [2:0]  outs = {ece, pins};
  int          num_errors = 0;
  int          checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  tcoc_core dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .carrier_partner_timer(cpt), .timer_out_pin(pins),
    .event_count_enable(ece), .carrier_out(car), .match_irq(mirq), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd_q, e);
    chk(er_q, er);
  endtask
  // Waits for a match, then counts matches and output edges over n cycles
  task automatic meas(input int k, input int n, input int ei, input int et);
    int c;
    int t;
    logic p;
    c = 0;
    t = 0;
    for (int i = 0; i < 400 && mirq[k] !== 1'b1; i++) @(negedge clk_sys);
    p = outs[k];
    repeat (n) begin
      @(negedge clk_sys);
      c += (mirq[k] === 1'b1);
      t += (outs[k] !== p);
      p = outs[k];
    end
    chk(c, ei);
    chk(mirq[k], 1'b1);
    if (et >= 0) chk(t, et);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 16), 32'h0000_0000, 1'b0);
      rd(8'(i * 16 + 4), 32'h0000_0000, 1'b0);
      rd(8'(i * 16 + 8), 32'h0000_0000, 1'b0);
    end
    rd(8'h40, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_modes();
    bus(1'b1, 8'h04, 32'h0000_0009);
    bus(1'b1, 8'h08, 32'h0000_0003);
    bus(1'b1, 8'h00, 32'h0000_0081);
    meas(0, 10, 1, 1);
    bus(1'b1, 8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000, 1'b0);
    bus(1'b1, 8'h00, 32'h0000_0089);
    bus(1'b1, 8'h08, 32'h0000_0003);
    meas(0, 10, 1, 2);
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0085);
    bus(1'b1, 8'h08, 32'h0000_0003);
    meas(0, 10, 1, 1);
    bus(1'b1, 8'h00, 32'h0000_0000);
  endtask
  task automatic t_carrier();
    bus(1'b1, 8'h14, 32'h0000_0009);
    bus(1'b1, 8'h18, 32'h0000_0003);
    // Idle level high while stopped, so the carrier gate has a level to pass
    bus(1'b1, 8'h10, 32'h0000_0007);
    bus(1'b1, 8'h10, 32'h0000_0087);
    bus(1'b1, 8'h18, 32'h0000_0003);
    meas(1, 4, 1, -1);
    chk(car, 1'b1);
    @(posedge clk_sys);
    cpt <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(car, 1'b0);
    @(posedge clk_sys);
    cpt <= 1'b1;
    bus(1'b1, 8'h10, 32'h0000_0000);
  endtask
  task automatic t_buffer();
    bus(1'b1, 8'h10, 32'h0000_00B9);
    bus(1'b1, 8'h18, 32'h0000_0003);
    bus(1'b1, 8'h18, 32'h0000_0006);
    rd(8'h18, 32'h0000_0003, 1'b0);
    repeat (80) @(posedge clk_sys);
    rd(8'h18, 32'h0000_0006, 1'b0);
    bus(1'b1, 8'h10, 32'h0000_0000);
  endtask
  task automatic t_third();
    bus(1'b1, 8'h24, 32'h0000_0001);
    bus(1'b1, 8'h20, 32'h0000_0080);
    meas(2, 2, 1, 1);
    bus(1'b1, 8'h20, 32'h0000_0000);
  endtask
  task automatic t_irq();
    rd(8'h30, 32'h0000_0007, 1'b0);
    bus(1'b1, 8'h34, 32'h0000_0001);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    bus(1'b1, 8'h34, 32'h0000_0000);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    bus(1'b1, 8'h30, 32'h0000_0007);
    rd(8'h30, 32'h0000_0000, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_carrier();
    t_buffer();
    t_third();
    t_irq();
    report_and_stop();
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb_timer_compare_output_core
`default_nettype wire
